// ### rtl/lirq_pkg.sv
// Constants, register map and types for the link interrupt event and
// isochronous receive mask block.
// Assumes a single 100 MHz clock and an APB3 master with 32-bit data.
//
// What this block does
// - A 32-bit mask enables reception for isochronous channels 0 to 31, and only packets from enabled channels are accepted.
// - Mask bit n enables channel n, for n from 31 down to 0.
// - An event bit latches to one on a rising edge of its source or on a one written at the event set address.
// - A latched event bit returns to zero only through a one written at the event clear address.
// - The event set address is 80h, the clear address 84h, and reads at 84h return events ANDed with the interrupt mask.
// - Event bits 31 and 29 to 27 always read zero and ignore writes.
// - Event bit 26 is raised when a PHY register data byte has arrived.
// - As cycle master, event bit 25 is raised when more than 125 us pass between cycle start transmit and subaction gap end.
// - The cycle-master enable bit is cleared whenever the cycle overrun event fires.
// - Event bit 24 is raised on any error that halts a context, such as a context going dead.
// - While event bit 24 is set, normal interrupts of the contexts that caused it are blocked.
package lirq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_ISO_MASK_SET  = 8'h78;
  localparam logic [ADDR_W-1:0] OFS_ISO_MASK_CLR  = 8'h7C;
  localparam logic [ADDR_W-1:0] OFS_EVENT_SET     = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CLR     = 8'h84;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_SET  = 8'h88;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_CLR  = 8'h8C;
  localparam logic [ADDR_W-1:0] OFS_LINK_CTRL     = 8'h90;

  localparam int EV_PHY_REG   = 26;
  localparam int EV_CYC_OVR   = 25;
  localparam int EV_FATAL     = 24;
  localparam int LC_CYC_MSTR  = 0;

  // Only the three documented sources are stored; all other bits read zero.
  localparam logic [DATA_W-1:0] EVENT_IMPL    = 32'h0700_0000;
  localparam logic [DATA_W-1:0] ISO_MASK_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] EVENT_RST     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IRQ_MASK_RST  = 32'h0000_0000;
  localparam logic              CYC_MSTR_RST  = 1'b0;

  localparam int CLK_FREQ_MHZ     = 100;
  localparam int CYCLE_LIMIT_US   = 125;
  localparam int CYCLE_LIMIT_CYC  = CYCLE_LIMIT_US * CLK_FREQ_MHZ;

  localparam int NUM_CTX = 4;

  typedef enum {
    REG_NONE,
    REG_ISO_SET,
    REG_ISO_CLR,
    REG_EV_SET,
    REG_EV_CLR,
    REG_IM_SET,
    REG_IM_CLR,
    REG_LCTRL
  } lirq_reg_t;

endpackage : lirq_pkg

// ### rtl/lirq_event_latch.sv
// Sticky event register with edge-detected sources and set/clear writes.
// Assumes sources are on the same clock and writes are one-cycle strobes.
`timescale 1ns/1ps
module lirq_event_latch #(
  parameter int                W    = 32,                 // Register width
  parameter logic [W-1:0]      IMPL = '1                  // Bits that exist
) (
  input  wire logic         clk,                          // Clock
  input  wire logic         rst,                          // Sync reset, high
  input  wire logic [W-1:0] src,                          // Source levels
  input  wire logic [W-1:0] swSet,                        // Write-one-to-set
  input  wire logic [W-1:0] swClr,                        // Write-one-to-clear
  output logic      [W-1:0] bits                          // Latched events
);
  import lirq_pkg::*;

  logic [W-1:0] srcPrev;
  logic [W-1:0] rise;

  assign rise = src & ~srcPrev;

  always_ff @(posedge clk) begin
    if (rst) begin
      srcPrev <= '0;
    end else begin
      srcPrev <= src;
    end
  end

  // only write clears; a set in the same cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      bits <= EVENT_RST[W-1:0];
    end else begin
      bits <= IMPL & ((bits & ~swClr) | swSet | rise);
    end
  end

  ev_hold_a: assert property (@(posedge clk) disable iff (rst)
    (bits & ~swClr) != (bits & ~swClr & {W{1'b0}}) |=> ((bits & $past(bits & ~swClr)) == $past(bits & ~swClr)))
    else $error("event bit dropped without a clear write");

endmodule : lirq_event_latch

// ### rtl/lirq_cycle_watch.sv
// Watches the time from cycle start transmit to subaction gap end.
// Assumes both markers are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module lirq_cycle_watch #(
  parameter int LIMIT = 12500                             // Allowed cycles
) (
  input  wire logic clk,                                  // Clock
  input  wire logic rst,                                  // Sync reset, high
  input  wire logic enable,                               // Cycle master on
  input  wire logic startTx,                              // Cycle start sent
  input  wire logic gapEnd,                               // Subaction gap end
  output logic      overrun                               // Overrun pulse
);
  localparam int CW = $clog2(LIMIT + 2);

  logic          running;
  logic [CW-1:0] cnt;

  // overrun after more than LIMIT cycles
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      running <= 1'b0;
      cnt     <= '0;
      overrun <= 1'b0;
    end else begin
      overrun <= 1'b0;
      if (startTx) begin
        running <= 1'b1;
        cnt     <= '0;
      end else if (running) begin
        if (gapEnd) begin
          running <= 1'b0;
        end else if (cnt == CW'(LIMIT)) begin
          overrun <= 1'b1;
          running <= 1'b0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

  ovr_timing_a: assert property (@(posedge clk) disable iff (rst)
    overrun |-> $past(running) && $past(cnt) == CW'(LIMIT) && !$past(gapEnd))
    else $error("overrun fired at the wrong count");

endmodule : lirq_cycle_watch

// ### rtl/lirq_top.sv
// Top of the interrupt event and isochronous receive mask block.
// Assumes an APB3 master on ref_clk and same-clock event sources.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module lirq_top #(
  parameter int CYCLE_LIMIT = lirq_pkg::CYCLE_LIMIT_CYC,   // Overrun cycles
  parameter int NCTX        = lirq_pkg::NUM_CTX            // DMA contexts
) (
  input  wire logic                          ref_clk,           // 100 MHz clock
  input  wire logic                          rst,               // Sync reset, high
  input  wire logic                          psel,              // APB select
  input  wire logic                          penable,           // APB enable
  input  wire logic                          pwrite,            // APB write
  input  wire logic [lirq_pkg::ADDR_W-1:0]   paddr,             // APB address
  input  wire logic [lirq_pkg::DATA_W-1:0]   pwdata,            // APB write data
  output logic                               pready,            // APB ready
  output logic      [lirq_pkg::DATA_W-1:0]   prdata,            // APB read data
  output logic                               pslverr,           // APB error
  input  wire logic                          isoPktValid,       // Iso header seen
  input  wire logic [5:0]                    isoPktChannel,     // Iso channel
  output logic                               isoPktAccept,      // Packet taken
  input  wire logic                          phyRegByteArrived, // PHY byte ready
  input  wire logic                          cycleStartTxBegin, // Cycle start sent
  input  wire logic                          subactionGapEnd,   // Gap end
  output logic                               cycleMasterEnable, // Cycle master on
  input  wire logic [NCTX-1:0]               ctxDead,           // Context halted
  output logic      [NCTX-1:0]               ctxIrqBlock,       // Block ctx irqs
  output logic                               irq                // Interrupt out
);
  import lirq_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  function automatic lirq_reg_t decodeReg(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_ISO_MASK_SET: decodeReg = REG_ISO_SET;
      OFS_ISO_MASK_CLR: decodeReg = REG_ISO_CLR;
      OFS_EVENT_SET:    decodeReg = REG_EV_SET;
      OFS_EVENT_CLR:    decodeReg = REG_EV_CLR;
      OFS_IRQ_MASK_SET: decodeReg = REG_IM_SET;
      OFS_IRQ_MASK_CLR: decodeReg = REG_IM_CLR;
      OFS_LINK_CTRL:    decodeReg = REG_LCTRL;
      default:          decodeReg = REG_NONE;
    endcase
  endfunction : decodeReg

  lirq_reg_t          sel;
  logic               access;
  logic               wrEn;
  logic [DATA_W-1:0]  isoMask;
  logic [DATA_W-1:0]  irqMask;
  logic [DATA_W-1:0]  evBits;
  logic [DATA_W-1:0]  evSrc;
  logic [DATA_W-1:0]  evSet;
  logic [DATA_W-1:0]  evClr;
  logic [DATA_W-1:0]  readVal;
  logic [NCTX-1:0]    deadPrev;
  logic [NCTX-1:0]    newDead;
  logic [NCTX-1:0]    culprit;
  logic               cycOverrun;

  assign sel    = decodeReg(paddr);
  assign access = psel && penable && pready;
  // Writes to an unmapped address are dropped and answered with an error.
  assign wrEn   = access && pwrite && (sel != REG_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, ready raised from the setup cycle.

  always_comb begin
    case (sel)
      REG_ISO_SET, REG_ISO_CLR: readVal = isoMask;
      // raw events at the set address
      REG_EV_SET:               readVal = evBits;
      // masked events at the clear address
      REG_EV_CLR:               readVal = evBits & irqMask;
      REG_IM_SET, REG_IM_CLR:   readVal = irqMask;
      REG_LCTRL:                readVal = {{(DATA_W-1){1'b0}}, cycleMasterEnable};
      default:                  readVal = '0;
    endcase
  end

  // Read data is captured in the setup cycle, so a read reflects state one
  // cycle before the access phase completes.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable && !pready;
      prdata  <= (psel && !penable && !pwrite) ? readVal : '0;
      pslverr <= psel && !penable && (sel == REG_NONE);
    end
  end

  apb_ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Isochronous receive channel mask and packet filter.

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      isoMask <= ISO_MASK_RST;
    end else if (wrEn && sel == REG_ISO_SET) begin
      isoMask <= isoMask | pwdata;
    end else if (wrEn && sel == REG_ISO_CLR) begin
      isoMask <= isoMask & ~pwdata;
    end
  end

  // bit n enables channel n; upper channels 32 to 63 are never accepted.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      isoPktAccept <= 1'b0;
    end else begin
      isoPktAccept <= isoPktValid && !isoPktChannel[5] && isoMask[isoPktChannel[4:0]];
    end
  end

  iso_filter_a: assert property (
    isoPktValid && !isoPktChannel[5] && isoMask[isoPktChannel[4:0]] |=> isoPktAccept)
    else $error("enabled channel packet not accepted");

  iso_reject_a: assert property (
    isoPktValid && (isoPktChannel[5] || !isoMask[isoPktChannel[4:0]]) |=> !isoPktAccept)
    else $error("disabled channel packet accepted");

  mask_set_a: assert property (
    wrEn && sel == REG_ISO_SET |=> (isoMask & $past(pwdata)) == $past(pwdata))
    else $error("mask set write lost a bit");

  mask_clr_a: assert property (
    wrEn && sel == REG_ISO_CLR |=> (isoMask & $past(pwdata)) == '0)
    else $error("mask clear write left a bit set");

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask (same layout as the event register).

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqMask <= IRQ_MASK_RST;
    end else if (wrEn && sel == REG_IM_SET) begin
      irqMask <= irqMask | pwdata;
    end else if (wrEn && sel == REG_IM_CLR) begin
      irqMask <= irqMask & ~pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link control: cycle-master enable.

  // overrun drops cycle master, winning over a same-cycle write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cycleMasterEnable <= CYC_MSTR_RST;
    end else if (cycOverrun) begin
      cycleMasterEnable <= 1'b0;
    end else if (wrEn && sel == REG_LCTRL) begin
      cycleMasterEnable <= pwdata[LC_CYC_MSTR];
    end
  end

  lirq_cycle_watch #(
    .LIMIT   (CYCLE_LIMIT)
  ) u_watch (
    .clk     (ref_clk),
    .rst     (rst),
    .enable  (cycleMasterEnable),
    .startTx (cycleStartTxBegin),
    .gapEnd  (subactionGapEnd),
    .overrun (cycOverrun)
  );

  ovr_drops_master_a: assert property (cycOverrun |=> !cycleMasterEnable)
    else $error("cycle master stayed on after overrun");

  ////////////////////////////////////////////////////////////////////////////
  // Event sources and the sticky event register.

  assign newDead = ctxDead & ~deadPrev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      deadPrev <= '0;
    end else begin
      deadPrev <= ctxDead;
    end
  end

  // PHY byte, overrun, any new dead context
  always_comb begin
    evSrc             = '0;
    evSrc[EV_PHY_REG] = phyRegByteArrived;
    evSrc[EV_CYC_OVR] = cycOverrun;
    evSrc[EV_FATAL]   = |newDead;
  end

  // set at 80h, clear at 84h
  assign evSet = (wrEn && sel == REG_EV_SET) ? pwdata : '0;
  assign evClr = (wrEn && sel == REG_EV_CLR) ? pwdata : '0;

  lirq_event_latch #(
    .W     (DATA_W),
    .IMPL  (EVENT_IMPL)
  ) u_events (
    .clk   (ref_clk),
    .rst   (rst),
    .src   (evSrc),
    .swSet (evSet),
    .swClr (evClr),
    .bits  (evBits)
  );

  ev_phy_set_a: assert property ($rose(phyRegByteArrived) |=> evBits[EV_PHY_REG])
    else $error("PHY byte event not latched");

  ev_fatal_set_a: assert property (|newDead |=> evBits[EV_FATAL])
    else $error("dead context did not raise the fatal event");

  ev_ovr_set_a: assert property (cycOverrun |=> evBits[EV_CYC_OVR])
    else $error("overrun did not raise its event");

  ev_reserved_a: assert property (evBits[31:27] == 5'h00)
    else $error("reserved event bit set");

  ev_sw_set_a: assert property (
    wrEn && sel == REG_EV_SET |=> (evBits & $past(pwdata & EVENT_IMPL)) == $past(pwdata & EVENT_IMPL))
    else $error("event set write lost a bit");

  ev_sticky_a: assert property (
    evBits[EV_PHY_REG] && !evClr[EV_PHY_REG] |=> evBits[EV_PHY_REG])
    else $error("PHY byte event cleared without a clear write");

  ////////////////////////////////////////////////////////////////////////////
  // Blocking of the contexts that caused the fatal event.

  // culprits are remembered while the fatal event stays set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      culprit <= '0;
    end else begin
      culprit <= (evBits[EV_FATAL] ? culprit : '0) | newDead;
    end
  end

  // block output follows the fatal bit with one cycle of lag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctxIrqBlock <= '0;
    end else begin
      ctxIrqBlock <= culprit & {NCTX{evBits[EV_FATAL]}};
    end
  end

  fatal_block_a: assert property (|ctxIrqBlock |-> $past(evBits[EV_FATAL]))
    else $error("context blocked without the fatal event");

  fatal_culprit_a: assert property (
    evBits[EV_FATAL] && $past(evBits[EV_FATAL]) && |newDead |=> ##1 (ctxIrqBlock & $past(newDead, 2)) == $past(newDead, 2))
    else $error("dead context not blocked");

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output: level, high while an unmasked event is pending.

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evBits & irqMask);
    end
  end

  rd_masked_a: assert property (
    psel && !penable && !pwrite && sel == REG_EV_CLR |=> prdata == $past(evBits & irqMask))
    else $error("clear address read not masked");

  rd_raw_a: assert property (
    psel && !penable && !pwrite && sel == REG_EV_SET |=> prdata == $past(evBits))
    else $error("set address read not raw events");

  irq_level_a: assert property (irq |-> $past(|(evBits & irqMask)))
    else $error("interrupt without an unmasked event");

endmodule : lirq_top

// ### bench/test_link_irq_event_and_iso_rx_mask.sv
// Self-checking bench for the interrupt event and isochronous receive mask block.
// Assumes the design files under rtl/ are compiled first; drives APB and all sources itself.
`timescale 1ns/1ps
module test_link_irq_event_and_iso_rx_mask;
  import lirq_pkg::*;
  localparam int LIM = 20;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready, pslverr, isoPktAccept, cycleMasterEnable, irq;
  logic [31:0] prdata;
  logic        isoPktValid = 1'b0, phyRegByteArrived = 1'b0, cycleStartTxBegin = 1'b0, subactionGapEnd = 1'b0;
  logic [5:0]  isoPktChannel = 6'h00;
  logic [3:0]  ctxDead = 4'h0, ctxIrqBlock;
  int          miscompares = 0, checks = 0;
  int unsigned rnd = 99, isoM = 0, evM = 0, imM = 0;
  logic        expQ[$];
  logic [31:0] r;
  logic        e;

  always #5 ref_clk = ~ref_clk;

  lirq_top #(.CYCLE_LIMIT(LIM), .NCTX(4)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .isoPktValid(isoPktValid), .isoPktChannel(isoPktChannel), .isoPktAccept(isoPktAccept),
    .phyRegByteArrived(phyRegByteArrived), .cycleStartTxBegin(cycleStartTxBegin),
    .subactionGapEnd(subactionGapEnd), .cycleMasterEnable(cycleMasterEnable), .ctxDead(ctxDead),
    .ctxIrqBlock(ctxIrqBlock), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic int unsigned xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs

  task automatic test_done();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask : chkReg

  task automatic chkSig(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t sig got=%h exp=%h", $time, got, exp);
    end
  endtask : chkSig

  // The request is held until pready is sampled high at a rising edge; only the watchdog ends a wait.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chkSig({3'b000, e}, 4'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chkReg(r, exp);
    chkSig({3'b000, e}, 4'h0);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end

  initial begin
    int unsigned v, ch;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_ISO_MASK_SET, 32'h0000_0000);
    rd(OFS_EVENT_CLR, 32'h0000_0000);
    apb(1'b0, 8'hA0, 32'h0000_0000);
    chkReg(r, 32'h0000_0000);
    chkSig({3'b000, e}, 4'h1);
    $display("test reset done");
    // Mask set and clear addresses, then a stream of packets on every channel range.
    v = xs();
    isoM |= v;
    wr(OFS_ISO_MASK_SET, v);
    rd(OFS_ISO_MASK_CLR, isoM);
    v = xs();
    isoM &= ~v;
    wr(OFS_ISO_MASK_CLR, v);
    rd(OFS_ISO_MASK_SET, isoM);
    for (int i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      if (i >= 2) chkSig({3'b000, isoPktAccept}, {3'b000, expQ.pop_front()});
      ch = xs() % 64;
      v = xs() % 4;
      isoPktValid <= (v != 0);
      isoPktChannel <= ch[5:0];
      expQ.push_back(v != 0 && ch < 32 && isoM[ch]);
    end
    @(posedge ref_clk);
    chkSig({3'b000, isoPktAccept}, {3'b000, expQ.pop_front()});
    isoPktValid <= 1'b0;
    @(posedge ref_clk);
    chkSig({3'b000, isoPktAccept}, {3'b000, expQ.pop_front()});
    $display("test iso mask done");
    // Software set, partial clear, masked view and the interrupt line.
    wr(OFS_EVENT_SET, 32'hFFFF_FFFF);
    evM = 32'h0700_0000;
    rd(OFS_EVENT_SET, evM);
    wr(OFS_EVENT_SET, 32'h0000_0000);
    wr(OFS_EVENT_CLR, 32'h0200_0000);
    evM = 32'h0500_0000;
    rd(OFS_EVENT_SET, evM);
    rd(OFS_EVENT_CLR, 32'h0000_0000);
    chkSig({3'b000, irq}, 4'h0);
    imM = 32'h0400_0000;
    wr(OFS_IRQ_MASK_SET, imM);
    rd(OFS_EVENT_CLR, evM & imM);
    chkSig({3'b000, irq}, 4'h1);
    wr(OFS_EVENT_CLR, 32'hFFFF_FFFF);
    evM = 0;
    rd(OFS_EVENT_SET, evM);
    chkSig({3'b000, irq}, 4'h0);
    $display("test software events done");
    // A source edge latches the bit, which stays after the source falls.
    @(posedge ref_clk);
    phyRegByteArrived <= 1'b1;
    repeat (2) @(posedge ref_clk);
    phyRegByteArrived <= 1'b0;
    evM = 32'h0400_0000;
    rd(OFS_EVENT_SET, evM);
    chkSig({3'b000, irq}, 4'h1);
    wr(OFS_EVENT_CLR, evM);
    evM = 0;
    $display("test source event done");
    // A gap in time keeps cycle master on; an overrun drops it and latches the event.
    wr(OFS_LINK_CTRL, 32'h0000_0001);
    rd(OFS_LINK_CTRL, 32'h0000_0001);
    @(posedge ref_clk);
    cycleStartTxBegin <= 1'b1;
    @(posedge ref_clk);
    cycleStartTxBegin <= 1'b0;
    repeat (LIM - 5) @(posedge ref_clk);
    subactionGapEnd <= 1'b1;
    @(posedge ref_clk);
    subactionGapEnd <= 1'b0;
    repeat (LIM + 5) @(posedge ref_clk);
    rd(OFS_EVENT_SET, 32'h0000_0000);
    chkSig({3'b000, cycleMasterEnable}, 4'h1);
    @(posedge ref_clk);
    cycleStartTxBegin <= 1'b1;
    @(posedge ref_clk);
    cycleStartTxBegin <= 1'b0;
    repeat (LIM + 5) @(posedge ref_clk);
    chkSig({3'b000, cycleMasterEnable}, 4'h0);
    rd(OFS_EVENT_SET, 32'h0200_0000);
    rd(OFS_LINK_CTRL, 32'h0000_0000);
    wr(OFS_EVENT_CLR, 32'h0200_0000);
    $display("test cycle overrun done");
    // A dead context latches the fatal event and blocks that context until cleared.
    @(posedge ref_clk);
    ctxDead <= 4'h2;
    repeat (4) @(posedge ref_clk);
    chkSig(ctxIrqBlock, 4'h2);
    // A second context dying while the fatal event stands joins the blocked set.
    ctxDead <= 4'h6;
    repeat (3) @(posedge ref_clk);
    chkSig(ctxIrqBlock, 4'h6);
    rd(OFS_EVENT_SET, 32'h0100_0000);
    wr(OFS_EVENT_CLR, 32'h0100_0000);
    repeat (3) @(posedge ref_clk);
    chkSig(ctxIrqBlock, 4'h0);
    ctxDead <= 4'h0;
    rd(OFS_EVENT_SET, 32'h0000_0000);
    $display("test fatal error done");
    test_done();
  end
endmodule : test_link_irq_event_and_iso_rx_mask
